/* File: cab_pkg.sv */
// Shared types and constants of the core's arithmetic, compare and flow-change execution stage.
// Assumes a front end that decodes instructions and fetches register, I/O and pointer operands.
package cab_pkg;

    // ========================================================================
    // Register map of the plain software port
    localparam logic [7:0] ADDR_STACK_POINTER_LOW = 8'h5d;
    localparam logic [7:0] ADDR_STATUS            = 8'h5f;
    localparam logic [7:0] RST_STACK_POINTER_LOW  = 8'hff;
    localparam logic [7:0] RST_STATUS             = 8'h00;
    localparam logic [15:0] RST_PC                = 16'h0000;

    // ========================================================================
    // Status register bit positions
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_Z = 1;
    localparam int unsigned FLG_N = 2;
    localparam int unsigned FLG_V = 3;
    localparam int unsigned FLG_S = 4;
    localparam int unsigned FLG_H = 5;
    localparam int unsigned FLG_T = 6;
    localparam int unsigned FLG_I = 7;

    // ========================================================================
    // Fixed values and counts
    localparam logic [7:0]  ALL_ONES_VALUE = 8'hff;
    localparam logic [7:0]  NEGATE_BASE    = 8'h00;
    localparam logic [15:0] PC_STEP        = 16'h0001;
    localparam logic [15:0] SKIP_SHORT     = 16'h0002;
    localparam logic [15:0] SKIP_LONG      = 16'h0003;
    localparam logic [15:0] CALL_LONG_RET  = 16'h0002;
    localparam logic [7:0]  CALL_STACK_DEC = 8'h02;

    // ========================================================================
    // Operations
    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADD_CARRY, OP_WORD_IMMEDIATE_SUM, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY,
        OP_SUB_CARRY_IMM, OP_WORD_IMMEDIATE_DIFF, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
        OP_NEGATE, OP_SET_ALL, OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
        OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT,
        OP_RELATIVE_JUMP, OP_RELATIVE_CALL, OP_POINTER_JUMP, OP_POINTER_CALL, OP_DIRECT_JUMP,
        OP_DIRECT_CALL, OP_EQUAL_COMPARE_SKIP, OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM,
        OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP, OP_IO_BIT_SET_SKIP,
        OP_STATUS_BIT_SET_BRANCH, OP_STATUS_BIT_CLEAR_BRANCH, OP_TEST, OP_MOVE
    } cab_op_e;

    typedef struct packed {
        logic        valid;
        cab_op_e     op;
        logic [7:0]  a;         // Destination operand, low byte of a word pair
        logic [7:0]  b;         // Source operand, high byte of a word pair
        logic [15:0] k;         // Constant, absolute target or sign-extended offset
        logic [2:0]  sel;       // Bit select
        logic [15:0] pc;        // Address of this instruction
        logic [15:0] zptr;
        logic [7:0]  io_val;
        logic        next_long; // Following instruction is two words
    } cab_req_s;

    typedef struct packed {
        logic        wr_en;
        logic        wr_hi_en;
        logic        to_r1r0;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic        push_en;
        logic [15:0] push_pc;
    } cab_res_s;

endpackage

/* File: cab_exec.sv */
// Execution stage for arithmetic, logic, multiply, compare, jump, skip and branch instructions.
// Assumes the front end holds the next request while busy is high and writes results back itself.
`timescale 1ns/1ps

module cab_exec
    import cab_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire cab_req_s    req,
    output cab_res_s         res_reg,
    output logic [15:0]      pc_reg,
    output logic [7:0]       status_reg,
    output logic             busy_reg,
    output logic [7:0]       stack_pointer_low_reg,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata_reg
);

    // ========================================================================
    // Helpers
    function automatic logic [10:0] arith8(input logic [7:0] x, input logic [7:0] y,
                                           input logic cin, input logic sub);
        logic [8:0] s;
        logic [4:0] hs;
        logic       v;
        s  = sub ? ({1'b0, x} - {1'b0, y} - {8'h00, cin}) : ({1'b0, x} + {1'b0, y} + {8'h00, cin});
        hs = sub ? ({1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin})
                 : ({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin});
        v  = sub ? ((x[7] & ~y[7] & ~s[7]) | (~x[7] & y[7] & s[7]))
                 : ((x[7] & y[7] & ~s[7]) | (~x[7] & ~y[7] & s[7]));
        return {hs[4], v, s[8], s[7:0]};
    endfunction

    function automatic logic [7:0] set_flags(input logic [7:0] f, input logic [7:0] r,
                                             input logic z_chain, input logic c, input logic v,
                                             input logic h, input logic upd_ch);
        logic [7:0] g;
        g        = f;
        g[FLG_Z] = (r == 8'h00) & z_chain;
        g[FLG_N] = r[7];
        g[FLG_V] = v;
        g[FLG_S] = r[7] ^ v;
        if (upd_ch) begin
            g[FLG_C] = c;
            g[FLG_H] = h;
        end
        return g;
    endfunction

    // ========================================================================
    // Next-state logic
    logic        accept;
    logic [7:0]  opnd;
    logic        use_cin;
    logic        is_sub;
    logic [10:0] ar;
    logic [16:0] wsum;
    logic [8:0]  mx;
    logic [8:0]  my;
    logic [17:0] prod;
    logic [15:0] p16;
    logic        cond_bit;
    logic        take;
    logic [7:0]  flags_next;
    logic [15:0] pc_next;
    logic        two_next;
    cab_res_s    res_next;

    assign accept = req.valid && !busy_reg;

    always_comb begin
        opnd    = (req.op inside {OP_SUB_IMM, OP_SUB_CARRY_IMM, OP_AND_IMM, OP_OR_IMM, OP_COMPARE_IMM})
                  ? req.k[7:0] : req.b;
        use_cin = req.op inside {OP_ADD_CARRY, OP_SUB_CARRY, OP_SUB_CARRY_IMM, OP_COMPARE_CARRY};
        is_sub  = !(req.op inside {OP_ADD, OP_ADD_CARRY});
        if (req.op == OP_NEGATE) begin
            ar = arith8(NEGATE_BASE, req.a, 1'b0, 1'b1);
        end else begin
            ar = arith8(req.a, opnd, use_cin & status_reg[FLG_C], is_sub);
        end
        wsum = (req.op == OP_WORD_IMMEDIATE_DIFF) ? ({1'b0, req.b, req.a} - {1'b0, req.k})
                                                  : ({1'b0, req.b, req.a} + {1'b0, req.k});
        mx   = (req.op inside {OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
                               OP_FRACTIONAL_MIXED_PRODUCT}) ? {req.a[7], req.a} : {1'b0, req.a};
        my   = (req.op inside {OP_SIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT})
               ? {req.b[7], req.b} : {1'b0, req.b};
        prod = 18'($signed(mx) * $signed(my));
        p16  = prod[15:0];
        unique case (req.op)
            OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP: cond_bit = req.b[req.sel];
            OP_IO_BIT_CLEAR_SKIP, OP_IO_BIT_SET_SKIP:   cond_bit = req.io_val[req.sel];
            OP_EQUAL_COMPARE_SKIP:                      cond_bit = (req.a == req.b);
            default: begin
                // Signed condition taken from N xor V directly
                cond_bit = (req.sel == 3'(FLG_S)) ? (status_reg[FLG_N] ^ status_reg[FLG_V])
                                                  : status_reg[req.sel];
            end
        endcase
        take = (req.op inside {OP_REG_BIT_CLEAR_SKIP, OP_IO_BIT_CLEAR_SKIP, OP_STATUS_BIT_CLEAR_BRANCH})
               ? !cond_bit : cond_bit;

        flags_next = status_reg;
        pc_next    = req.pc + PC_STEP;
        two_next   = 1'b0;
        res_next   = '0;
        unique case (req.op)
            OP_NOP: ;
            OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_CARRY_IMM, OP_NEGATE: begin
                res_next.wr_en = 1'b1;
                res_next.lo    = ar[7:0];
                flags_next     = set_flags(status_reg, ar[7:0], !use_cin || !is_sub || status_reg[FLG_Z],
                                           ar[8], ar[9], ar[10], 1'b1);
            end
            OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM: begin
                flags_next = set_flags(status_reg, ar[7:0], !use_cin || status_reg[FLG_Z],
                                       ar[8], ar[9], ar[10], 1'b1);
            end
            OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFF: begin
                res_next.wr_en    = 1'b1;
                res_next.wr_hi_en = 1'b1;
                res_next.lo       = wsum[7:0];
                res_next.hi       = wsum[15:8];
                flags_next[FLG_Z] = (wsum[15:0] == 16'h0000);
                flags_next[FLG_C] = wsum[16];
                flags_next[FLG_N] = wsum[15];
                flags_next[FLG_V] = (req.op == OP_WORD_IMMEDIATE_SUM) ? (~req.b[7] & wsum[15])
                                                                      : (req.b[7] & ~wsum[15]);
                flags_next[FLG_S] = wsum[15] ^ flags_next[FLG_V];
            end
            OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_TEST: begin
                res_next.wr_en = (req.op != OP_TEST);
                res_next.lo    = (req.op inside {OP_AND, OP_AND_IMM, OP_TEST}) ? (req.a & opnd) :
                                 (req.op == OP_XOR) ? (req.a ^ opnd) : (req.a | opnd);
                flags_next     = set_flags(status_reg, res_next.lo, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            end
            OP_SET_ALL: begin
                res_next.wr_en = 1'b1;
                res_next.lo    = ALL_ONES_VALUE;
            end
            OP_MOVE: begin
                res_next.wr_en = 1'b1;
                res_next.lo    = req.b;
            end
            OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT: begin
                res_next.wr_en    = 1'b1;
                res_next.wr_hi_en = 1'b1;
                res_next.to_r1r0  = 1'b1;
                {res_next.hi, res_next.lo} = p16;
                flags_next[FLG_C] = p16[15];
                flags_next[FLG_Z] = (p16 == 16'h0000);
            end
            OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT: begin
                res_next.wr_en    = 1'b1;
                res_next.wr_hi_en = 1'b1;
                res_next.to_r1r0  = 1'b1;
                {res_next.hi, res_next.lo} = {p16[14:0], 1'b0};
                flags_next[FLG_C] = p16[15];
                flags_next[FLG_Z] = ({p16[14:0], 1'b0} == 16'h0000);
            end
            OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
                pc_next          = req.pc + req.k + PC_STEP;
                res_next.push_en = (req.op == OP_RELATIVE_CALL);
                res_next.push_pc = req.pc + PC_STEP;
            end
            OP_POINTER_JUMP, OP_POINTER_CALL, OP_DIRECT_JUMP, OP_DIRECT_CALL: begin
                pc_next          = (req.op inside {OP_POINTER_JUMP, OP_POINTER_CALL}) ? req.zptr : req.k;
                two_next         = 1'b1;
                res_next.push_en = (req.op inside {OP_POINTER_CALL, OP_DIRECT_CALL});
                res_next.push_pc = req.pc + ((req.op == OP_DIRECT_CALL) ? CALL_LONG_RET : PC_STEP);
            end
            OP_EQUAL_COMPARE_SKIP, OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP,
            OP_IO_BIT_SET_SKIP: begin
                if (take) begin
                    pc_next  = req.pc + (req.next_long ? SKIP_LONG : SKIP_SHORT);
                    two_next = 1'b1;
                end
            end
            OP_STATUS_BIT_SET_BRANCH, OP_STATUS_BIT_CLEAR_BRANCH: begin
                if (take) begin
                    pc_next  = req.pc + req.k + PC_STEP;
                    two_next = 1'b1;
                end
            end
        endcase
    end

    // ========================================================================
    // Results, program counter and busy
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            res_reg  <= '0;
            pc_reg   <= RST_PC;
            busy_reg <= 1'b0;
        end else begin
            res_reg  <= accept ? res_next : '0;
            busy_reg <= accept && two_next;
            if (accept) begin
                pc_reg <= pc_next;
            end
        end
    end

    // ========================================================================
    // Status register; an executing instruction wins over a software write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_reg <= RST_STATUS;
        end else if (accept) begin
            status_reg <= flags_next;
        end else if (reg_wr && reg_addr == ADDR_STATUS) begin
            status_reg <= reg_wdata;
        end
    end

    // ========================================================================
    // Stack pointer low byte; calls reserve two bytes for the return address
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stack_pointer_low_reg <= RST_STACK_POINTER_LOW;
        end else if (accept && res_next.push_en) begin
            stack_pointer_low_reg <= stack_pointer_low_reg - CALL_STACK_DEC;
        end else if (reg_wr && reg_addr == ADDR_STACK_POINTER_LOW) begin
            stack_pointer_low_reg <= reg_wdata;
        end
    end

    // ========================================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_STACK_POINTER_LOW: reg_rdata_reg <= stack_pointer_low_reg;
                ADDR_STATUS:            reg_rdata_reg <= status_reg;
                default:                reg_rdata_reg <= 8'h00;
            endcase
        end else begin
            reg_rdata_reg <= 8'h00;
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_ADD_SUM: assert property (accept && req.op == OP_ADD |=> res_reg.wr_en
        && res_reg.lo == 8'($past(req.a) + $past(req.b))
        && status_reg[FLG_C] == ((9'($past(req.a)) + 9'($past(req.b))) > 9'h0ff))
        else $error("add result or carry wrong");
    AST_WORD_SUM: assert property (accept && req.op == OP_WORD_IMMEDIATE_SUM |=>
        {res_reg.hi, res_reg.lo} == $past({req.b, req.a}) + $past(req.k) && res_reg.wr_hi_en)
        else $error("word sum wrong");
    AST_SUB_BORROW: assert property (accept && req.op == OP_SUB |=>
        status_reg[FLG_C] == ($past(req.a) < $past(req.b)) && res_reg.lo == 8'($past(req.a) - $past(req.b)))
        else $error("subtract borrow wrong");
    AST_LOGIC_V: assert property (accept && req.op inside {OP_AND, OP_OR, OP_XOR}
        |=> !status_reg[FLG_V] && status_reg[FLG_C] == $past(status_reg[FLG_C]))
        else $error("logic op flags wrong");
    AST_NEGATE: assert property (accept && req.op == OP_NEGATE |=>
        res_reg.lo == 8'(8'h00 - $past(req.a)) && status_reg[FLG_C] == ($past(req.a) != 8'h00))
        else $error("negate wrong");
    AST_SET_ALL: assert property (accept && req.op == OP_SET_ALL |=>
        res_reg.lo == 8'hff && $stable(status_reg)) else $error("set all wrong");
    AST_PRODUCT: assert property (accept && req.op == OP_UNSIGNED_PRODUCT |=> res_reg.to_r1r0
        && {res_reg.hi, res_reg.lo} == 16'($past(req.a)) * 16'($past(req.b))) else $error("product wrong");
    AST_REL_JUMP: assert property (accept && req.op == OP_RELATIVE_JUMP |=>
        pc_reg == $past(req.pc) + $past(req.k) + 16'h0001 && !busy_reg) else $error("relative jump wrong");
    AST_FAR_JUMP: assert property (accept && req.op == OP_POINTER_JUMP |=>
        pc_reg == $past(req.zptr) ##0 busy_reg ##1 !busy_reg) else $error("pointer jump timing wrong");
    AST_COMPARE: assert property (accept && req.op == OP_COMPARE |=> !res_reg.wr_en
        && status_reg[FLG_Z] == ($past(req.a) == $past(req.b))) else $error("compare wrong");
    AST_BRANCH_IDLE: assert property (accept && req.op == OP_STATUS_BIT_SET_BRANCH
        && !status_reg[req.sel] && req.sel != 3'(FLG_S) |=> !busy_reg && pc_reg == $past(req.pc) + 16'h0001)
        else $error("untaken branch cost wrong");
    AST_MOVE: assert property (accept && req.op == OP_MOVE |=> res_reg.lo == $past(req.b)
        && $stable(status_reg)) else $error("move wrong");

endmodule

/* File: cab_far_model.sv */
// Far-side model: the stack that takes return addresses pushed by calls.
// Assumes res_reg of the execution stage, one clock, synchronous active-low reset.
`timescale 1ns/1ps
module cab_far_model
    import cab_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     rst_n,
    input  wire cab_res_s res,
    output logic [15:0]   stk_top
);
    // ========================================================================
    // Stack top
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stk_top <= 16'h0000;
        end else if (res.push_en) begin
            stk_top <= res.push_pc;
        end
    end
endmodule

/* File: tb_top.sv */
// Self-checking bench of the execution stage: ALU, flags, branches, skips, calls, registers.
// Assumes cab_exec and cab_far_model; 50 MHz clock, requests driven by non-blocking assignment.
`timescale 1ns/1ps
module tb_top
    import cab_pkg::*;
;
    logic        ref_clk, rst_n, reg_wr, reg_rd, busy, nl_v;
    cab_req_s    req;
    cab_res_s    res;
    logic [15:0] pc, z_v, stk_top;
    logic [7:0]  st, stack_pointer_low, rdat, reg_addr, reg_wdata, io_v;
    logic [2:0]  sel_v;
    int          n_mismatch, comparisons;

    cab_exec u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .res_reg(res), .pc_reg(pc),
        .status_reg(st), .busy_reg(busy), .stack_pointer_low_reg(stack_pointer_low), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(rdat));
    cab_far_model u_far (.ref_clk(ref_clk), .rst_n(rst_n), .res(res), .stk_top(stk_top));

    // ========================================================================
    // Shared tasks
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ex(cab_op_e o, logic [7:0] a, logic [7:0] b, logic [15:0] k, logic [15:0] p);
        @(posedge ref_clk);
        req <= '{1'b1, o, a, b, k, sel_v, p, z_v, io_v, nl_v};
        @(posedge ref_clk);
        req.valid <= 1'b0;
        #1;
    endtask
    task automatic wr(logic [7:0] ad, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] ad, logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk8("rdata", e, rdat);
    endtask
    task automatic alu(cab_op_e o, logic [7:0] a, b, logic [15:0] k, logic [7:0] ew, elo, est);
        ex(o, a, b, k, 16'h0010);
        chk8("wr_en", ew, {7'h00, res.wr_en});
        if (ew[0]) chk8("lo", elo, res.lo);
        chk8("status", est, st);
        chk16("pc", 16'h0011, pc);
    endtask
    task automatic flow(cab_op_e o, logic [7:0] a, b, logic [15:0] k, p, epc, logic [7:0] eb);
        ex(o, a, b, k, p);
        chk16("pc", epc, pc);
        chk8("busy", eb, {7'h00, busy});
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_regs;
        rd(ADDR_STACK_POINTER_LOW, RST_STACK_POINTER_LOW);
        rd(ADDR_STATUS, RST_STATUS);
        rd(8'h60, 8'h00);
        wr(ADDR_STACK_POINTER_LOW, 8'h40);
        rd(ADDR_STACK_POINTER_LOW, 8'h40);
        wr(ADDR_STATUS, 8'h00);
    endtask
    task automatic t_alu;
        alu(OP_ADD, 8'h80, 8'h80, 16'h0, 8'h1, 8'h00, 8'h1b);
        alu(OP_ADD_CARRY, 8'h0f, 8'h00, 16'h0, 8'h1, 8'h10, 8'h20);
        alu(OP_SUB, 8'h00, 8'h01, 16'h0, 8'h1, 8'hff, 8'h35);
        alu(OP_SUB_CARRY_IMM, 8'h10, 8'h00, 16'h0f, 8'h1, 8'h00, 8'h20);
        alu(OP_NEGATE, 8'h80, 8'h00, 16'h0, 8'h1, 8'h80, 8'h0d);
        alu(OP_AND, 8'hf0, 8'h8f, 16'h0, 8'h1, 8'h80, 8'h15);
        alu(OP_OR_IMM, 8'h00, 8'h00, 16'h0, 8'h1, 8'h00, 8'h03);
        alu(OP_SET_ALL, 8'h00, 8'h00, 16'h0, 8'h1, ALL_ONES_VALUE, 8'h03);
        alu(OP_MOVE, 8'h00, 8'h5a, 16'h0, 8'h1, 8'h5a, 8'h03);
        alu(OP_UNSIGNED_PRODUCT, 8'hff, 8'hff, 16'h0, 8'h1, 8'h01, 8'h01);
        chk8("hi", 8'hfe, res.hi);
        chk8("to_r1r0", 8'h01, {7'h00, res.to_r1r0});
        alu(OP_FRACTIONAL_UNSIGNED_PRODUCT, 8'h80, 8'h80, 16'h0, 8'h1, 8'h00, 8'h00);
        chk8("hi", 8'h80, res.hi);
        alu(OP_COMPARE, 8'h05, 8'h05, 16'h0, 8'h0, 8'h00, 8'h02);
        ex(OP_TEST, 8'h00, 8'h00, 16'h0, 16'h0010);
        chk8("status", 8'h02, st);
        alu(OP_WORD_IMMEDIATE_SUM, 8'hff, 8'hff, 16'h1, 8'h1, 8'h00, 8'h03);
        chk8("hi", 8'h00, res.hi);
        alu(OP_WORD_IMMEDIATE_DIFF, 8'h00, 8'h00, 16'h1, 8'h1, 8'hff, 8'h15);
        alu(OP_XOR, 8'hff, 8'h0f, 16'h0, 8'h1, 8'hf0, 8'h15);
        alu(OP_SUB_CARRY, 8'h05, 8'h04, 16'h0, 8'h1, 8'h00, 8'h00);
        alu(OP_SUB_IMM, 8'h03, 8'h00, 16'h05, 8'h1, 8'hfe, 8'h35);
        alu(OP_COMPARE_CARRY, 8'h01, 8'h00, 16'h0, 8'h0, 8'h00, 8'h00);
        alu(OP_COMPARE_IMM, 8'h80, 8'h00, 16'h01, 8'h0, 8'h00, 8'h38);
        alu(OP_SIGNED_PRODUCT, 8'hff, 8'h02, 16'h0, 8'h1, 8'hfe, 8'h39);
        chk8("hi", 8'hff, res.hi);
        alu(OP_MIXED_SIGN_PRODUCT, 8'hff, 8'hff, 16'h0, 8'h1, 8'h01, 8'h39);
        chk8("hi", 8'hff, res.hi);
        alu(OP_FRACTIONAL_SIGNED_PRODUCT, 8'hc0, 8'h40, 16'h0, 8'h1, 8'h00, 8'h39);
        chk8("hi", 8'he0, res.hi);
        alu(OP_NOP, 8'h00, 8'h00, 16'h0, 8'h0, 8'h00, 8'h39);
        wr(ADDR_STATUS, 8'h15);
    endtask
    task automatic t_flow;
        sel_v = FLG_C;
        flow(OP_STATUS_BIT_SET_BRANCH, 8'h0, 8'h0, 16'h4, 16'h20, 16'h25, 8'h1);
        flow(OP_STATUS_BIT_CLEAR_BRANCH, 8'h0, 8'h0, 16'h4, 16'h20, 16'h21, 8'h0);
        sel_v = FLG_S;
        flow(OP_STATUS_BIT_CLEAR_BRANCH, 8'h0, 8'h0, 16'h4, 16'h20, 16'h21, 8'h0);
        flow(OP_STATUS_BIT_SET_BRANCH, 8'h0, 8'h0, 16'hfffc, 16'h20, 16'h1d, 8'h1);
        sel_v = FLG_H;
        flow(OP_STATUS_BIT_CLEAR_BRANCH, 8'h0, 8'h0, 16'h4, 16'h20, 16'h25, 8'h1);
        chk8("status", 8'h15, st);
        wr(ADDR_STATUS, 8'h80);
        sel_v = FLG_I;
        flow(OP_STATUS_BIT_SET_BRANCH, 8'h0, 8'h0, 16'h4, 16'h20, 16'h25, 8'h1);
        flow(OP_STATUS_BIT_CLEAR_BRANCH, 8'h0, 8'h0, 16'h4, 16'h20, 16'h21, 8'h0);
        sel_v = 3'd0;
        nl_v = 1'b1;
        flow(OP_EQUAL_COMPARE_SKIP, 8'h07, 8'h07, 16'h0, 16'h40, 16'h43, 8'h1);
        nl_v = 1'b0;
        flow(OP_EQUAL_COMPARE_SKIP, 8'h07, 8'h06, 16'h0, 16'h40, 16'h41, 8'h0);
        flow(OP_REG_BIT_CLEAR_SKIP, 8'hfe, 8'hfe, 16'h0, 16'h40, 16'h42, 8'h1);
        flow(OP_REG_BIT_SET_SKIP, 8'hfe, 8'hfe, 16'h0, 16'h40, 16'h41, 8'h0);
        io_v = 8'h08;
        sel_v = 3'd3;
        flow(OP_IO_BIT_SET_SKIP, 8'h0, 8'h0, 16'h0, 16'h40, 16'h42, 8'h1);
        flow(OP_IO_BIT_CLEAR_SKIP, 8'h0, 8'h0, 16'h0, 16'h40, 16'h41, 8'h0);
    endtask
    task automatic t_jump;
        z_v = 16'h1234;
        flow(OP_RELATIVE_JUMP, 8'h0, 8'h0, 16'hfffe, 16'h10, 16'h0f, 8'h0);
        flow(OP_POINTER_JUMP, 8'h0, 8'h0, 16'h0, 16'h10, 16'h1234, 8'h1);
        flow(OP_DIRECT_JUMP, 8'h0, 8'h0, 16'h0abc, 16'h10, 16'h0abc, 8'h1);
        flow(OP_RELATIVE_CALL, 8'h0, 8'h0, 16'h3, 16'h50, 16'h54, 8'h0);
        chk16("push_pc", 16'h0051, res.push_pc);
        chk8("spl", 8'h3e, stack_pointer_low);
        flow(OP_DIRECT_CALL, 8'h0, 8'h0, 16'h0200, 16'h60, 16'h0200, 8'h1);
        chk16("push_pc", 16'h0062, res.push_pc);
        flow(OP_POINTER_CALL, 8'h0, 8'h0, 16'h0, 16'h70, 16'h1234, 8'h1);
        rd(ADDR_STACK_POINTER_LOW, 8'h3a);
        chk16("stack_top", 16'h0071, stk_top);
        chk8("status", 8'h80, st);
    endtask

    // ========================================================================
    // Run control
    task automatic close_out;
        $display("Counts: mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #400000;
        n_mismatch++;
        close_out;
    end
    initial begin
        rst_n = 1'b0;
        req = '0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {sel_v, z_v, io_v, nl_v} = '0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs;
        t_alu;
        t_flow;
        t_jump;
        close_out;
    end
endmodule
